/* File: core/ppmc_pkg.sv */
// Package of constants for the PHY power and mode control block
package ppmc_pkg;

	// ------------------------------------------------------------
	// Register offsets (word index on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] PPMC_REG_CTRL   = 4'h0;
	localparam logic [3:0] PPMC_REG_STAT   = 4'h1;
	localparam logic [3:0] PPMC_REG_XCTRL2 = 4'h2;
	localparam logic [3:0] PPMC_REG_LATCH  = 4'h3;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int PPMC_CTRL_SWRST = 15;
	localparam int PPMC_CTRL_SPEED = 13;
	localparam int PPMC_CTRL_ANEN  = 12;
	localparam int PPMC_CTRL_PDN   = 11;
	localparam logic [15:0] PPMC_CTRL_RST = 16'h3000;

	// ------------------------------------------------------------
	// Extended control 2 fields
	// ------------------------------------------------------------
	localparam int PPMC_X2_PS100 = 0;
	localparam int PPMC_X2_PS10  = 1;
	localparam logic [15:0] PPMC_X2_RST = 16'h0000;

	// ------------------------------------------------------------
	// Latching status defaults: low bits idle high, others low
	// ------------------------------------------------------------
	localparam logic [15:0] PPMC_LL_RST  = 16'h00FF;
	localparam logic [15:0] PPMC_LH_RST  = 16'h0000;
	localparam logic [7:0]  PPMC_LMX_RST = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int PPMC_CLK_NS       = 100;
	localparam int PPMC_SWRST_CYC    = 2;
	localparam int PPMC_EXIT_NS      = 640;
	localparam int PPMC_EXIT_CYC     =
		(PPMC_EXIT_NS + PPMC_CLK_NS - 1) / PPMC_CLK_NS;
	localparam int PPMC_CNT_W        = 4;

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PPMC_S_DOWN = 2'b00,
		PPMC_S_WAKE = 2'b01,
		PPMC_S_RUN  = 2'b10,
		PPMC_S_SRST = 2'b11
	} ppmc_state_e;

endpackage : ppmc_pkg

/* File: core/ppmc_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module ppmc_sync
	import ppmc_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : ppmc_sync

/* File: core/ppmc_latch.sv */
// Latching status bits: latch-low, latch-high and latch-maximum
`timescale 1ns/1ps
module ppmc_latch
	import ppmc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        clr_all,
	input  wire logic        rd_clr,
	input  wire logic [7:0]  ev_low,
	input  wire logic [7:0]  ev_high,
	input  wire logic [7:0]  level_in,
	output logic      [15:0] latch_low_bits,
	output logic      [15:0] latch_high_bits,
	output logic      [7:0]  latch_max_bits
);
	// ------------------------------------------------------------
	// Per-bit sticky flags; an event wins over a read clear
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (!rstn || clr_all)
				begin
					latch_low_bits[i]  <= PPMC_LL_RST[i];
					latch_high_bits[i] <= PPMC_LH_RST[i];
				end
				else
				begin
					if (!ev_low[i])
						latch_low_bits[i] <= 1'b0;
					else if (rd_clr)
						latch_low_bits[i] <= 1'b1;
					if (ev_high[i])
						latch_high_bits[i] <= 1'b1;
					else if (rd_clr)
						latch_high_bits[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign latch_low_bits[15:8]  = PPMC_LL_RST[15:8];
	assign latch_high_bits[15:8] = PPMC_LH_RST[15:8];

	always_ff @(posedge clk)
	begin
		if (!rstn || clr_all)
			latch_max_bits <= PPMC_LMX_RST;
		else if (level_in > latch_max_bits)
			latch_max_bits <= level_in;
		else if (rd_clr)
			latch_max_bits <= level_in;
	end
endmodule : ppmc_latch

/* File: core/ppmc_top.sv */
// Power-down, power-save and mode control of a 10/100 PHY
//
// Notes on behaviour
// [R1] Power down while reset pin low or the power-down control bit set.
// [R2] Powered down: functions off, MAC outputs zero, management port alive.
// [R3] Powered down: both pair transmit outputs released to high impedance.
// [R4] Bit power-down keeps registers, resets only latching status bits.
// [R5] Reset power-down returns every management register bit to default.
// [R6] 100M save bit one disables 100M modules while running 10M.
// [R7] 10M save bit one disables 10M modules while running 100M.
// [R8] Autoneg enable from select pin in hardware mode, control bit in software.
// [R9] Autoneg enabled: adopt best mode common to both ends.
// [R10] 100M path uses serialising, 4B/5B, NRZI, MLT-3 and scrambling.
// [R11] Configuration from straps when source pin zero, registers when one.
// [R12] Software reset does not enter the power-down state.
// [R13] Leave power-down only with reset pin high and power-down bit clear.
// [R14] Station clears power-down over management port before expecting data.
`timescale 1ns/1ps
module ppmc_top
	import ppmc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        hw_reset_low_pin,
	input  wire logic        config_source_pin,
	input  wire logic        autoneg_select_pin,
	input  wire logic        speed_select_pin,
	input  wire logic        link_up,
	input  wire logic        partner_100,
	input  wire logic        mac_rx_valid,
	input  wire logic [3:0]  mac_rxd,
	input  wire logic        tx_line_data,
	input  wire logic [7:0]  ev_low,
	input  wire logic [7:0]  ev_high,
	input  wire logic [7:0]  level_in,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	output logic             power_down,
	output logic             mod100_en,
	output logic             mod10_en,
	output logic             autoneg_en,
	output logic             speed_100,
	output logic             coding_100_en,
	output logic             mac_rx_valid_out,
	output logic      [3:0]  mac_rxd_out,
	output logic             pair_tx_pos_o,
	output logic             pair_tx_neg_o,
	output logic             pair_tx_oe
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] pins_s;
	logic       rst_pin_n;
	logic       cfg_sw;
	logic       autoneg_select_pin_s;
	logic       spdsel_s;

	ppmc_sync #(.W(4)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.d    ({hw_reset_low_pin, config_source_pin,
		        autoneg_select_pin, speed_select_pin}),
		.q    (pins_s)
	);

	assign rst_pin_n = pins_s[3];
	assign cfg_sw    = pins_s[2];
	assign autoneg_select_pin_s   = pins_s[1];
	assign spdsel_s  = pins_s[0];

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	logic [15:0]          ctrl_r;
	logic [15:0]          xctrl2_r;
	ppmc_state_e          state_r;
	logic [PPMC_CNT_W-1:0] cnt_r;
	logic                 hw_reset;
	logic                 sw_reset;
	logic                 pdn_bit;
	logic                 pdn_bit_d_r;
	logic                 lat_clr;
	logic                 lat_rd;
	logic [15:0]          ll_w;
	logic [15:0]          lh_w;
	logic [7:0]           lmx_w;
	logic                 down_nxt;
	logic                 spd_nxt;
	logic                 an_nxt;

	// Held pin reset or block reset both count as a device reset
	assign hw_reset = !rst_pin_n; // [R1]
	assign pdn_bit  = ctrl_r[PPMC_CTRL_PDN];
	assign sw_reset = (state_r == PPMC_S_SRST);
	assign lat_rd   = reg_rd && (reg_addr == PPMC_REG_LATCH);

	// ------------------------------------------------------------
	// Control register: reset restores defaults, bit entry keeps it
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn || hw_reset)
			ctrl_r <= PPMC_CTRL_RST; // [R5]
		else if (sw_reset)
			ctrl_r <= PPMC_CTRL_RST; // [R12]
		else if (reg_wr && reg_addr == PPMC_REG_CTRL)
			ctrl_r <= reg_wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn || hw_reset || sw_reset)
			xctrl2_r <= PPMC_X2_RST; // [R5]
		else if (reg_wr && reg_addr == PPMC_REG_XCTRL2)
			xctrl2_r <= reg_wdata;
	end

	// Latching bits reset on any reset and on power-down bit entry
	always_ff @(posedge clk)
	begin
		if (!rstn)
			pdn_bit_d_r <= 1'b0;
		else
			pdn_bit_d_r <= pdn_bit;
	end

	assign lat_clr = hw_reset || sw_reset || (pdn_bit && !pdn_bit_d_r); // [R4]

	ppmc_latch u_latch (
		.clk             (clk),
		.rstn            (rstn),
		.clr_all         (lat_clr),
		.rd_clr          (lat_rd),
		.ev_low          (ev_low),
		.ev_high         (ev_high),
		.level_in        (level_in),
		.latch_low_bits  (ll_w),
		.latch_high_bits (lh_w),
		.latch_max_bits  (lmx_w)
	);

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state_r <= PPMC_S_DOWN;
			cnt_r   <= '0;
		end
		else
		begin
			case (state_r)
				PPMC_S_DOWN:
				begin
					cnt_r <= '0;
					if (!hw_reset && !pdn_bit) // [R13]
						state_r <= PPMC_S_WAKE;
				end
				PPMC_S_WAKE:
				begin
					// Pins released a fixed time after the exit
					if (hw_reset || pdn_bit)
						state_r <= PPMC_S_DOWN; // [R1]
					else if (cnt_r == PPMC_CNT_W'(PPMC_EXIT_CYC - 1))
						state_r <= PPMC_S_RUN;
					else
						cnt_r <= cnt_r + 1'b1;
				end
				PPMC_S_RUN:
				begin
					cnt_r <= '0;
					if (hw_reset || pdn_bit)
						state_r <= PPMC_S_DOWN; // [R1]
					else if (reg_wr && reg_addr == PPMC_REG_CTRL &&
					         reg_wdata[PPMC_CTRL_SWRST])
						state_r <= PPMC_S_SRST;
				end
				PPMC_S_SRST:
				begin
					// Stays powered, only the outputs are quiet
					if (hw_reset)
						state_r <= PPMC_S_DOWN;
					else if (cnt_r == PPMC_CNT_W'(PPMC_SWRST_CYC - 1))
						state_r <= PPMC_S_RUN; // [R12]
					else
						cnt_r <= cnt_r + 1'b1;
				end
				default:
					state_r <= PPMC_S_DOWN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mode selection
	// ------------------------------------------------------------
	always_comb
	begin
		if (cfg_sw) // [R11]
		begin
			an_nxt  = ctrl_r[PPMC_CTRL_ANEN]; // [R8]
			spd_nxt = ctrl_r[PPMC_CTRL_SPEED];
		end
		else
		begin
			an_nxt  = autoneg_select_pin_s; // [R8]
			spd_nxt = spdsel_s;
		end
		// Partner capability limits the speed when negotiating with link up
		if (an_nxt && link_up)
			spd_nxt = spd_nxt && partner_100; // [R9]
	end

	assign down_nxt = (state_r != PPMC_S_RUN);

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			power_down    <= 1'b1;
			autoneg_en    <= 1'b0;
			speed_100     <= 1'b0;
			mod100_en     <= 1'b0;
			mod10_en      <= 1'b0;
			coding_100_en <= 1'b0;
		end
		else
		begin
			power_down <= (state_r == PPMC_S_DOWN) ||
			              (state_r == PPMC_S_WAKE); // [R1]
			autoneg_en <= !down_nxt && an_nxt; // [R2]
			speed_100  <= spd_nxt;
			mod100_en  <= !down_nxt &&
			              (spd_nxt || !xctrl2_r[PPMC_X2_PS100]); // [R6]
			mod10_en   <= !down_nxt &&
			              (!spd_nxt || !xctrl2_r[PPMC_X2_PS10]); // [R7]
			coding_100_en <= !down_nxt && spd_nxt; // [R10]
		end
	end

	// ------------------------------------------------------------
	// MAC-side and line outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn || down_nxt)
		begin
			mac_rx_valid_out <= 1'b0; // [R2]
			mac_rxd_out      <= 4'h0;
			pair_tx_pos_o    <= 1'b0;
			pair_tx_neg_o    <= 1'b0;
			pair_tx_oe       <= 1'b0; // [R3]
		end
		else
		begin
			mac_rx_valid_out <= mac_rx_valid;
			mac_rxd_out      <= mac_rxd;
			pair_tx_pos_o    <= tx_line_data;
			pair_tx_neg_o    <= !tx_line_data;
			pair_tx_oe       <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Register read port: works in power-down too
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				PPMC_REG_CTRL:   reg_rdata <= ctrl_r; // [R14]
				PPMC_REG_STAT:   reg_rdata <= {10'h000, cfg_sw,
				                               state_r, autoneg_en,
				                               speed_100, power_down};
				PPMC_REG_XCTRL2: reg_rdata <= xctrl2_r;
				PPMC_REG_LATCH:  reg_rdata <= {lmx_w, ll_w[3:0],
				                               lh_w[3:0]};
				default:         reg_rdata <= 16'h0000;
			endcase
		end
		else
			reg_rdata <= 16'h0000;
	end
endmodule : ppmc_top

/* File: tb/ppmc_properties.sv */
// Checker of power-down, reset and register port timing
`timescale 1ns/1ps
module ppmc_properties
	import ppmc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        hw_reset_low_pin,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        power_down,
	input wire logic        mac_rx_valid_out,
	input wire logic [3:0]  mac_rxd_out,
	input wire logic        pair_tx_oe,
	input wire logic        coding_100_en
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	logic ctl_wr;
	// Pin reset blocks control writes, so only writes with pin high count
	assign ctl_wr = reg_wr && reg_addr == PPMC_REG_CTRL && hw_reset_low_pin;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence held_down_s;
		power_down && $past(power_down);
	endsequence

	pin_down_a: assert property (!hw_reset_low_pin |-> ##[1:4] power_down)
		else $error("pin reset did not power down");
	bit_down_a: assert property (ctl_wr && reg_wdata[PPMC_CTRL_PDN]
		&& !reg_wdata[PPMC_CTRL_SWRST] |-> ##[1:3] power_down)
		else $error("power-down bit ignored");
	mac_zero_a: assert property (held_down_s |->
		!mac_rx_valid_out && mac_rxd_out == 4'h0)
		else $error("MAC outputs active while down");
	tx_hiz_a: assert property (held_down_s |-> !pair_tx_oe)
		else $error("pair driven while down");
	func_off_a: assert property (held_down_s |-> !coding_100_en)
		else $error("coding active while down");
	wake_exit_a: assert property ($fell(power_down) |->
		$past(power_down, 7) && hw_reset_low_pin)
		else $error("early power-down exit");
	srst_up_a: assert property (ctl_wr && reg_wdata[PPMC_CTRL_SWRST]
		&& !power_down |=> !power_down [*4])
		else $error("soft reset powered down");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside read slot");
	unmapped_a: assert property ($past(reg_rd)
		&& $past(reg_addr) > PPMC_REG_LATCH |-> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule : ppmc_properties

bind ppmc_top ppmc_properties i_prop (.clk, .rstn, .hw_reset_low_pin,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_down,
	.mac_rx_valid_out, .mac_rxd_out, .pair_tx_oe, .coding_100_en);

/* File: tb/ppmc_far_end.sv */
// MAC and line traffic source facing the block
`timescale 1ns/1ps
module ppmc_far_end
(
	input  wire logic       clk,
	output logic            rx_valid,
	output logic      [3:0] rxd,
	output logic            line_bit
);
	logic [3:0] cnt_r = 4'h0;

	// New nibble every cycle, so a stuck or late path shows at once
	always_ff @(posedge clk)
	begin
		cnt_r <= cnt_r + 4'h1;
	end
	assign rxd      = cnt_r;
	assign rx_valid = cnt_r[0];
	assign line_bit = cnt_r[1];
endmodule : ppmc_far_end

/* File: tb/tb.sv */
// Self-checking bench of the PHY power and mode control block
`timescale 1ns/1ps
module tb
	import ppmc_pkg::*;
;
	logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        hw_reset_low_pin = 1'b1, config_source_pin = 1'b1;
	logic        autoneg_select_pin = 1'b0, speed_select_pin = 1'b1;
	logic        link_up = 1'b1, partner_100 = 1'b0;
	logic [3:0]  reg_addr = 4'h0, mac_rxd;
	logic [7:0]  ev_low = 8'hFF, ev_high = 8'h00, level_in = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_v;
	logic        mac_rx_valid, tx_line_data, power_down, mod100_en;
	logic        mod10_en, autoneg_en, speed_100, coding_100_en;
	logic        mac_rx_valid_out, pair_tx_pos_o, pair_tx_neg_o, pair_tx_oe;
	logic [3:0]  mac_rxd_out;
	int          err_count = 0, checks_done = 0;

	always #50 clk = ~clk;

	ppmc_top i_dut (.clk, .rstn, .hw_reset_low_pin, .config_source_pin,
		.autoneg_select_pin, .speed_select_pin, .link_up, .partner_100,
		.mac_rx_valid, .mac_rxd, .tx_line_data, .ev_low, .ev_high, .level_in,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .power_down,
		.mod100_en, .mod10_en, .autoneg_en, .speed_100, .coding_100_en,
		.mac_rx_valid_out, .mac_rxd_out, .pair_tx_pos_o, .pair_tx_neg_o,
		.pair_tx_oe);
	ppmc_far_end i_far (.clk, .rx_valid(mac_rx_valid), .rxd(mac_rxd),
		.line_bit(tx_line_data));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(logic [3:0] a);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		rd_v = reg_rdata;
	endtask : rd

	// Bounded wait; returns the cycles spent
	task automatic wait_pd(logic v, output int n);
		n = 0;
		while (power_down !== v && n < 40)
		begin
			tick(1);
			n++;
		end
		chk("power_down", power_down, v);
	endtask : wait_pd

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_boot;
		int n;
		logic [3:0] p;
		wait_pd(1'b0, n);
		chk("wake span", n >= PPMC_EXIT_CYC + 1, 1'b1);
		tick(2);
		p = mac_rxd - 4'h1;
		chk("tx oe", pair_tx_oe, 1'b1);
		chk("mac path", {mac_rx_valid_out, mac_rxd_out}, {p[0], p});
		chk("pair lines", {pair_tx_pos_o, pair_tx_neg_o}, {p[1], !p[1]});
		rd(PPMC_REG_STAT);
		chk("status", rd_v, {10'h000, 1'b1, PPMC_S_RUN, 3'b100});
		rd(PPMC_REG_CTRL);
		chk("ctrl", rd_v, PPMC_CTRL_RST);
		rd(PPMC_REG_XCTRL2);
		chk("xctrl2", rd_v, PPMC_X2_RST);
		wr(4'h9, 16'hFFFF);
		rd(4'h9);
		chk("unmapped", rd_v, 16'h0000);
		$display("boot test done");
	endtask : t_boot

	task automatic t_save;
		for (int i = 0; i < 8; i++)
		begin
			wr(PPMC_REG_XCTRL2, {14'h0, i[1:0]});
			wr(PPMC_REG_CTRL, {2'b00, i[2], 13'h0000});
			tick(3);
			chk("speed", speed_100, i[2]);
			chk("mod100", mod100_en, !(i[PPMC_X2_PS100] && !i[2]));
			chk("mod10", mod10_en, !(i[PPMC_X2_PS10] && i[2]));
			chk("coding", coding_100_en, i[2]);
		end
		$display("power save test done");
	endtask : t_save

	task automatic t_an;
		@(posedge clk);
		config_source_pin <= 1'b0;
		for (int j = 0; j < 4; j++)
		begin
			@(posedge clk);
			autoneg_select_pin <= j[0];
			partner_100        <= j[1];
			tick(5);
			chk("an strap", autoneg_en, j[0]);
			chk("an speed", speed_100, j[0] ? j[1] : 1'b1);
		end
		@(posedge clk);
		config_source_pin <= 1'b1;
		partner_100       <= 1'b0;
		wr(PPMC_REG_CTRL, PPMC_CTRL_RST);
		tick(5);
		chk("an reg", autoneg_en, 1'b1);
		chk("an speed reg", speed_100, 1'b0);
		wr(PPMC_REG_CTRL, 16'h2000);
		tick(3);
		chk("an off", autoneg_en, 1'b0);
		chk("fixed speed", speed_100, 1'b1);
		$display("autoneg test done");
	endtask : t_an

	task automatic t_pdn;
		int n;
		wr(PPMC_REG_XCTRL2, 16'h0003);
		@(posedge clk);
		ev_high  <= 8'h01;
		level_in <= 8'h05;
		@(posedge clk);
		ev_high  <= 8'h00;
		level_in <= 8'h00;
		wr(PPMC_REG_CTRL, PPMC_CTRL_RST | (16'h1 << PPMC_CTRL_PDN));
		tick(3);
		chk("pd bit", power_down, 1'b1);
		chk("mac off", {mac_rx_valid_out, mac_rxd_out}, 5'h00);
		chk("tx hiz", pair_tx_oe, 1'b0);
		rd(PPMC_REG_XCTRL2);
		chk("xctrl2 kept", rd_v, 16'h0003);
		rd(PPMC_REG_LATCH);
		chk("latch", rd_v, {PPMC_LMX_RST, PPMC_LL_RST[3:0],
			PPMC_LH_RST[3:0]});
		tick(12);
		chk("still down", power_down, 1'b1);
		// Station clears the bit over the still-live register port
		wr(PPMC_REG_CTRL, PPMC_CTRL_RST);
		wait_pd(1'b0, n);
		$display("power-down bit test done");
	endtask : t_pdn

	task automatic t_srst;
		wr(PPMC_REG_XCTRL2, 16'h0001);
		wr(PPMC_REG_CTRL, PPMC_CTRL_RST | (16'h1 << PPMC_CTRL_SWRST));
		repeat (4)
		begin
			tick(1);
			chk("pd soft", power_down, 1'b0);
		end
		rd(PPMC_REG_CTRL);
		chk("ctrl self clear", rd_v, PPMC_CTRL_RST);
		rd(PPMC_REG_XCTRL2);
		chk("xctrl2 soft", rd_v, PPMC_X2_RST);
		$display("soft reset test done");
	endtask : t_srst

	task automatic t_pin;
		int n;
		wr(PPMC_REG_XCTRL2, 16'h0003);
		@(posedge clk);
		hw_reset_low_pin <= 1'b0;
		tick(6);
		chk("pd pin", power_down, 1'b1);
		chk("tx hiz pin", pair_tx_oe, 1'b0);
		@(posedge clk);
		hw_reset_low_pin <= 1'b1;
		wait_pd(1'b0, n);
		rd(PPMC_REG_XCTRL2);
		chk("xctrl2 pin", rd_v, PPMC_X2_RST);
		rd(PPMC_REG_CTRL);
		chk("ctrl pin", rd_v, PPMC_CTRL_RST);
		$display("pin reset test done");
	endtask : t_pin

	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_boot();
		t_save();
		t_an();
		t_pdn();
		t_srst();
		t_pin();
		report_and_stop();
	end

	// Whole run is some 200 cycles; ten times that means a hang
	initial
	begin
		#200000;
		err_count++;
		report_and_stop();
	end
endmodule : tb
